// ===== src/asp_map.svh
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH

`define ASP_OFS_DATA      3'h0
`define ASP_OFS_STATUS    3'h1
`define ASP_OFS_CONTROL   3'h2
`define ASP_OFS_BAUD      3'h3
`define ASP_OFS_PORT_DIR  3'h4
`define ASP_OFS_PORT_OUT  3'h5
`define ASP_OFS_PORT_IN   3'h6

`define ASP_CTL_RX_DONE_IRQ_ENABLE     7
`define ASP_CTL_TX_DONE_IRQ_ENABLE     6
`define ASP_CTL_TX_EMPTY_IRQ_ENABLE     5
`define ASP_CTL_RECEIVER_ENABLE      4
`define ASP_CTL_TRANSMITTER_ENABLE      3
`define ASP_CTL_NINE_BIT_MODE      2
`define ASP_CTL_RECEIVED_NINTH_BIT      1
`define ASP_CTL_TRANSMIT_NINTH_BIT      0

`define ASP_STA_RXC       7
`define ASP_STA_TXC       6
`define ASP_STA_DATA_REG_EMPTY_FLAG      5
`define ASP_STA_FE        4
`define ASP_STA_OR        3

`define ASP_PIN_TX        1
`define ASP_PIN_RX        0

`define ASP_CTL_RST       8'h00
`define ASP_BAUD_RST      8'h00
`define ASP_PORT_RST      2'h0

`define ASP_OVS_LAST      4'hf
`define ASP_SMP_FIRST     5'h01
`define ASP_SMP_A         5'h08
`define ASP_SMP_B         5'h09
`define ASP_SMP_C         5'h0a
`define ASP_SMP_LAST      5'h10
`define ASP_BITS_8        4'ha
`define ASP_BITS_9        4'hb
`define ASP_DATA_8        4'h8
`define ASP_DATA_9        4'h9

`endif

// ===== src/asp_pkg.sv
// Types of the serial port: machine states and the packed state record
package asp_pkg;

  typedef enum logic {ASP_TX_IDLE, ASP_TX_SHIFT} asp_tx_st_t;

  typedef enum logic [1:0] {ASP_RX_IDLE, ASP_RX_START, ASP_RX_DATA} asp_rx_st_t;

  typedef struct packed {
    logic [1:0]  rx_sync;
    logic [1:0]  txp_sync;
    logic [7:0]  ctl;
    logic [7:0]  baud;
    logic [7:0]  baud_cnt;
    logic [1:0]  dir;
    logic [1:0]  pout;
    logic [8:0]  tx_hold;
    logic        hold_full;
    asp_tx_st_t  tx_st;
    logic [10:0] tx_shift;
    logic [3:0]  tx_bits;
    logic [3:0]  tx_sub;
    logic        tx_line;
    logic        transmit_complete_flag;
    asp_rx_st_t  rx_st;
    logic [4:0]  rx_smp;
    logic [3:0]  rx_bit;
    logic [1:0]  rx_vote;
    logic [8:0]  rx_shift;
    logic [7:0]  rdr;
    logic        receive_complete_flag;
    logic        fe;
    logic        ovr;
    logic [7:0]  rd_data;
    logic        tx_pin_o;
    logic        tx_pin_oe;
    logic        rx_pin_o;
    logic        rx_pin_oe;
    logic        rx_pullup;
    logic        irq_rx;
    logic        irq_tx;
    logic        irq_empty;
  } asp_state_t;

endpackage : asp_pkg

// ===== src/asp_top.sv
// Full-duplex asynchronous serial port with 16x oversampled receiver
// Notes on behaviour
// - Start bit at bit boundary, then LSB first
// - After stop bit, reload pending data, set empty
// - Nothing pending: transmit complete after stop time
// - Transmitter enable forces transmit pin to output
// - Receive line sampled at sixteen times baud
// - Single zero sample while idle starts detection
// - Majority one on samples 8-10 rejects start
// - Data bits taken by majority of 8-10
// - Zero-majority stop bit sets framing error
// - Reading data register clears framing error
// - Character end with free slot loads data, sets complete
// - Data address: reads receive, writes transmit
// - Nine-bit mode stores received ninth bit
// - Unread data: overrun set, new character lost
// - Receiver enable forces receive pin to input
// - Ninth transmitted bit from transmit ninth bit
// - Receive-complete interrupt when enabled and global
// - Transmit-complete interrupt when enabled and global
// - Data-empty interrupt when enabled and global
// - Receiver off: no receive flags set
// - Vector ack or written one clears complete
// - Empty flag sets on move to shifter
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "asp_map.svh"

module asp_top
  import asp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Interrupt side
  input  wire logic       global_irq_en,
  input  wire logic       tx_done_vec_ack,
  output logic            irq_rx_done,
  output logic            irq_tx_done,
  output logic            irq_tx_empty,
  // Transmit pin
  input  wire logic       tx_pin_i,
  output logic            tx_pin_o,
  output logic            tx_pin_oe,
  // Receive pin
  input  wire logic       rx_pin_i,
  output logic            rx_pin_o,
  output logic            rx_pin_oe,
  output logic            rx_pullup
);

  asp_state_t q_ff;
  asp_state_t nxt_q;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3

  logic       tick;
  logic       rx_in;
  logic       vote;
  logic       transmitter_enable;
  logic       receiver_enable;
  logic       nine;
  logic       wr_data;
  logic       rd_data_acc;
  logic       xfer;
  logic       tx_end;
  logic       rx_done;
  logic       rx_slot_free;
  logic [3:0] nbits;
  logic [3:0] ndata;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    tick         = (q_ff.baud_cnt == q_ff.baud);
    rx_in        = q_ff.rx_sync[1];
    vote         = maj3(q_ff.rx_vote[1], q_ff.rx_vote[0], rx_in);
    transmitter_enable         = q_ff.ctl[`ASP_CTL_TRANSMITTER_ENABLE];
    receiver_enable         = q_ff.ctl[`ASP_CTL_RECEIVER_ENABLE];
    nine         = q_ff.ctl[`ASP_CTL_NINE_BIT_MODE];
    nbits        = nine ? `ASP_BITS_9 : `ASP_BITS_8;
    ndata        = nine ? `ASP_DATA_9 : `ASP_DATA_8;
    wr_data      = reg_wr && (reg_addr == `ASP_OFS_DATA);
    rd_data_acc  = reg_rd && (reg_addr == `ASP_OFS_DATA);
    xfer         = (q_ff.tx_st == ASP_TX_IDLE) && q_ff.hold_full && transmitter_enable;
    tx_end       = (q_ff.tx_st == ASP_TX_SHIFT) && tick && (q_ff.tx_sub == 4'h0)
                   && (q_ff.tx_bits == 4'h0);
    rx_done      = (q_ff.rx_st == ASP_RX_DATA) && tick && (q_ff.rx_smp == `ASP_SMP_C)
                   && (q_ff.rx_bit == ndata);
    // A read in the same cycle frees the slot, so no overrun is raised
    rx_slot_free = !q_ff.receive_complete_flag || rd_data_acc;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_q = q_ff;
    // Pins from outside pass two flops first
    nxt_q.rx_sync  = {q_ff.rx_sync[0], rx_pin_i};
    nxt_q.txp_sync = {q_ff.txp_sync[0], tx_pin_i};
    nxt_q.baud_cnt = tick ? 8'h00 : q_ff.baud_cnt + 8'h01;

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `ASP_OFS_CONTROL: begin
          nxt_q.ctl = {reg_wdata[7:2], q_ff.ctl[`ASP_CTL_RECEIVED_NINTH_BIT], reg_wdata[0]};
        end
        `ASP_OFS_BAUD: begin
          nxt_q.baud = reg_wdata;
        end
        `ASP_OFS_PORT_DIR: begin
          nxt_q.dir = reg_wdata[1:0];
        end
        `ASP_OFS_PORT_OUT: begin
          nxt_q.pout = reg_wdata[1:0];
        end
        default: begin
        end
      endcase
    end

    // clear by vector or written one
    if (tx_done_vec_ack || (reg_wr && (reg_addr == `ASP_OFS_STATUS)
                            && reg_wdata[`ASP_STA_TXC])) begin
      nxt_q.transmit_complete_flag = 1'b0;
    end

    // ninth bit captured with the data write
    if (wr_data) begin
      nxt_q.tx_hold = {q_ff.ctl[`ASP_CTL_TRANSMIT_NINTH_BIT], reg_wdata};
    end
    nxt_q.hold_full = (q_ff.hold_full && !xfer && !(tx_end && q_ff.hold_full)) || wr_data;

    // Transmitter
    if (tick) begin
      nxt_q.tx_sub = q_ff.tx_sub + 4'h1;
    end
    unique case (q_ff.tx_st)
      ASP_TX_IDLE: begin
        nxt_q.tx_line = 1'b1;
        if (xfer) begin
          nxt_q.tx_shift = {1'b1, nine ? q_ff.tx_hold[8] : 1'b1, q_ff.tx_hold[7:0], 1'b0};
          nxt_q.tx_bits  = nbits;
          nxt_q.tx_st    = ASP_TX_SHIFT;
        end
      end
      ASP_TX_SHIFT: begin
        if (tick && (q_ff.tx_sub == 4'h0)) begin
          if (q_ff.tx_bits != 4'h0) begin
            nxt_q.tx_line  = q_ff.tx_shift[0];
            nxt_q.tx_shift = {1'b1, q_ff.tx_shift[10:1]};
            nxt_q.tx_bits  = q_ff.tx_bits - 4'h1;
          end else if (q_ff.hold_full) begin
            nxt_q.tx_line  = 1'b0;
            nxt_q.tx_shift = {1'b1, 1'b1, nine ? q_ff.tx_hold[8] : 1'b1, q_ff.tx_hold[7:0]};
            nxt_q.tx_bits  = nbits - 4'h1;
          end else begin
            // stop bit held one bit time
            nxt_q.transmit_complete_flag   = 1'b1;
            nxt_q.tx_st = ASP_TX_IDLE;
          end
        end
      end
    endcase

    // Receiver; disabling it mid-character abandons the character
    if (!receiver_enable) begin
      nxt_q.rx_st = ASP_RX_IDLE;
    end else if (tick) begin
      // every divider tick is one sample
      nxt_q.rx_smp = (q_ff.rx_smp == `ASP_SMP_LAST) ? `ASP_SMP_FIRST
                                                    : q_ff.rx_smp + 5'h01;
      if ((q_ff.rx_smp == `ASP_SMP_A) || (q_ff.rx_smp == `ASP_SMP_B)) begin
        nxt_q.rx_vote = {q_ff.rx_vote[0], rx_in};
      end
      unique case (q_ff.rx_st)
        ASP_RX_IDLE: begin
          // one zero sample is sample one
          if (!rx_in) begin
            nxt_q.rx_st  = ASP_RX_START;
            nxt_q.rx_smp = 5'h02;
          end
        end
        ASP_RX_START: begin
          if (q_ff.rx_smp == `ASP_SMP_C) begin
            if (vote) begin
              nxt_q.rx_st = ASP_RX_IDLE;
            end else begin
              nxt_q.rx_st  = ASP_RX_DATA;
              nxt_q.rx_bit = 4'h0;
            end
          end
        end
        ASP_RX_DATA: begin
          if ((q_ff.rx_smp == `ASP_SMP_C) && (q_ff.rx_bit != ndata)) begin
            nxt_q.rx_shift = {vote, q_ff.rx_shift[8:1]};
            nxt_q.rx_bit   = q_ff.rx_bit + 4'h1;
          end
          if (rx_done) begin
            nxt_q.rx_st = ASP_RX_IDLE;
          end
        end
        default: begin
          nxt_q.rx_st = ASP_RX_IDLE;
        end
      endcase
    end

    if (rd_data_acc) begin
      nxt_q.receive_complete_flag = 1'b0;
      nxt_q.fe  = 1'b0;
      nxt_q.ovr = 1'b0;
    end
    if (rx_done && receiver_enable) begin
      if (rx_slot_free) begin
        nxt_q.receive_complete_flag = 1'b1;
        nxt_q.rdr = nine ? q_ff.rx_shift[7:0] : q_ff.rx_shift[8:1];
        nxt_q.fe  = !vote;
        if (nine) begin
          nxt_q.ctl[`ASP_CTL_RECEIVED_NINTH_BIT] = q_ff.rx_shift[8];
        end
      end else begin
        nxt_q.ovr = 1'b1;
      end
    end

    // Read data, valid in the cycle after the strobe only
    nxt_q.rd_data = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `ASP_OFS_DATA:     nxt_q.rd_data = q_ff.rdr;
        `ASP_OFS_STATUS:   nxt_q.rd_data = {q_ff.receive_complete_flag, q_ff.transmit_complete_flag, !q_ff.hold_full,
                                            q_ff.fe, q_ff.ovr, 3'h0};
        `ASP_OFS_CONTROL:  nxt_q.rd_data = q_ff.ctl;
        `ASP_OFS_BAUD:     nxt_q.rd_data = q_ff.baud;
        `ASP_OFS_PORT_DIR: nxt_q.rd_data = {6'h00, q_ff.dir};
        `ASP_OFS_PORT_OUT: nxt_q.rd_data = {6'h00, q_ff.pout};
        `ASP_OFS_PORT_IN:  nxt_q.rd_data = {6'h00, q_ff.txp_sync[1], q_ff.rx_sync[1]};
        default:           nxt_q.rd_data = 8'h00;
      endcase
    end

    // transmitter owns its pin while enabled or finishing
    nxt_q.tx_pin_oe = transmitter_enable || (q_ff.tx_st == ASP_TX_SHIFT) || q_ff.dir[`ASP_PIN_TX];
    nxt_q.tx_pin_o  = (transmitter_enable || (q_ff.tx_st == ASP_TX_SHIFT)) ? q_ff.tx_line
                                                              : q_ff.pout[`ASP_PIN_TX];
    nxt_q.rx_pin_oe = !receiver_enable && q_ff.dir[`ASP_PIN_RX];
    nxt_q.rx_pin_o  = q_ff.pout[`ASP_PIN_RX];
    nxt_q.rx_pullup = q_ff.pout[`ASP_PIN_RX] && (receiver_enable || !q_ff.dir[`ASP_PIN_RX]);

    nxt_q.irq_rx    = q_ff.receive_complete_flag && q_ff.ctl[`ASP_CTL_RX_DONE_IRQ_ENABLE] && global_irq_en;
    nxt_q.irq_tx    = q_ff.transmit_complete_flag && q_ff.ctl[`ASP_CTL_TX_DONE_IRQ_ENABLE] && global_irq_en;
    nxt_q.irq_empty = !q_ff.hold_full && q_ff.ctl[`ASP_CTL_TX_EMPTY_IRQ_ENABLE] && global_irq_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_ff           <= '0;
      q_ff.rx_sync   <= 2'h3;
      q_ff.txp_sync  <= 2'h3;
      q_ff.ctl       <= `ASP_CTL_RST;
      q_ff.baud      <= `ASP_BAUD_RST;
      q_ff.dir       <= `ASP_PORT_RST;
      q_ff.pout      <= `ASP_PORT_RST;
      q_ff.tx_st     <= ASP_TX_IDLE;
      q_ff.rx_st     <= ASP_RX_IDLE;
      q_ff.tx_shift  <= 11'h7ff;
      q_ff.tx_line   <= 1'b1;
      q_ff.tx_pin_o  <= 1'b1;
    end else if (ce) begin
      q_ff <= nxt_q;
    end
  end

  assign reg_rdata    = q_ff.rd_data;
  assign irq_rx_done  = q_ff.irq_rx;
  assign irq_tx_done  = q_ff.irq_tx;
  assign irq_tx_empty = q_ff.irq_empty;
  assign tx_pin_o     = q_ff.tx_pin_o;
  assign tx_pin_oe    = q_ff.tx_pin_oe;
  assign rx_pin_o     = q_ff.rx_pin_o;
  assign rx_pin_oe    = q_ff.rx_pin_oe;
  assign rx_pullup    = q_ff.rx_pullup;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !ce);

  property p_tx_start;
    (q_ff.tx_st == ASP_TX_SHIFT) && tick && (q_ff.tx_sub == 4'h0) && (q_ff.tx_bits == nbits)
    |=> !q_ff.tx_line;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start bit not driven");

  property p_reload;
    tx_end && q_ff.hold_full |=> !q_ff.tx_line && (q_ff.hold_full == $past(wr_data))
                                 && (!q_ff.transmit_complete_flag || $past(q_ff.transmit_complete_flag));
  endproperty
  a_reload: assert property (p_reload) else $error("pending data not reloaded");

  property p_txc_set;
    tx_end && !q_ff.hold_full |=> q_ff.transmit_complete_flag && (q_ff.tx_st == ASP_TX_IDLE);
  endproperty
  a_txc_set: assert property (p_txc_set) else $error("transmit complete missing");

  property p_tx_pin;
    transmitter_enable |=> q_ff.tx_pin_oe;
  endproperty
  a_tx_pin: assert property (p_tx_pin) else $error("transmit pin not output");

  property p_noise;
    receiver_enable && tick && (q_ff.rx_st == ASP_RX_START) && (q_ff.rx_smp == `ASP_SMP_C) && vote
    |=> q_ff.rx_st == ASP_RX_IDLE;
  endproperty
  a_noise: assert property (p_noise) else $error("noisy start accepted");

  property p_rxc;
    rx_done && receiver_enable && rx_slot_free |=> q_ff.receive_complete_flag && (q_ff.fe == !$past(vote));
  endproperty
  a_rxc: assert property (p_rxc) else $error("character not delivered");

  property p_fe_clear;
    rd_data_acc && !rx_done |=> !q_ff.fe && !q_ff.receive_complete_flag;
  endproperty
  a_fe_clear: assert property (p_fe_clear) else $error("flags kept after read");

  property p_overrun;
    rx_done && receiver_enable && !rx_slot_free |=> q_ff.ovr && $stable(q_ff.rdr);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_rx_off;
    !receiver_enable && !q_ff.receive_complete_flag && !rd_data_acc |=> !q_ff.receive_complete_flag;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("flag set while disabled");

  property p_irq_rx;
    q_ff.receive_complete_flag && q_ff.ctl[`ASP_CTL_RX_DONE_IRQ_ENABLE] && global_irq_en |=> irq_rx_done;
  endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("receive request missing");

  property p_data_reg_empty_flag;
    xfer && !wr_data |=> !q_ff.hold_full ##1 1'b1;
  endproperty
  a_data_reg_empty_flag: assert property (p_data_reg_empty_flag) else $error("empty flag not set");

  c_frame_sent: cover property (tx_end && !q_ff.hold_full);
  c_back_to_back: cover property (tx_end && q_ff.hold_full);
  c_rx_char: cover property (rx_done && rx_slot_free);
  c_rx_overrun: cover property (rx_done && !rx_slot_free);

endmodule : asp_top

// ===== verif/asp_remote.sv
// Remote serial transmitter and receiver facing the port pins
`timescale 1ns/10ps

module asp_remote #(
  parameter int BIT_CLKS = 32
) (
  // Clock
  input  wire logic clk,
  // Serial lines
  output logic      rx_line,
  input  wire logic tx_line
);
  logic [9:0] got_q[$];
  int         nbits = 8;

  initial rx_line = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // ninth bit follows eighth
  task automatic send(input logic [8:0] d, input logic stop);
    rx_line <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      rx_line <= d[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rx_line <= stop;
    repeat (BIT_CLKS) @(posedge clk);
    rx_line <= 1'b1;
    // One idle clock, so a following frame never redrives in this step
    @(posedge clk);
  endtask : send

  // Short low pulse, too brief to pass as a start bit
  task automatic spike(input int n);
    rx_line <= 1'b0;
    repeat (n) @(posedge clk);
    rx_line <= 1'b1;
  endtask : spike

  //////////////////////////////////////////////////////////////////////////////
  // Samples mid-bit; stop bit lands just above the data bits
  initial begin : rx_side
    logic [9:0] d;
    forever begin
      @(negedge tx_line);
      d = '0;
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i <= nbits; i++) begin
        repeat (BIT_CLKS) @(posedge clk);
        d[i] = tx_line;
      end
      got_q.push_back(d);
    end
  end
endmodule : asp_remote

// ===== verif/asp_top_bench.sv
// Self-checking bench of the serial port against a remote serial partner
`timescale 1ns/10ps
`include "asp_map.svh"

module asp_top_bench;
  localparam logic [7:0] BAUD  = 8'h01;
  localparam int         BIT   = 16 * (int'(BAUD) + 1);
  localparam logic [2:0] A_DAT = `ASP_OFS_DATA;
  localparam logic [2:0] A_STA = `ASP_OFS_STATUS;
  localparam logic [2:0] A_CTL = `ASP_OFS_CONTROL;

  logic       clk             = 1'b0;
  logic       sys_rst         = 1'b1;
  logic [2:0] reg_addr        = 3'h0;
  logic [7:0] reg_wdata       = 8'h00;
  logic       reg_wr          = 1'b0;
  logic       reg_rd          = 1'b0;
  logic       global_irq_en   = 1'b1;
  logic       tx_done_vec_ack = 1'b0;
  logic [7:0] reg_rdata;
  logic       irq_rx_done;
  logic       irq_tx_done;
  logic       irq_tx_empty;
  logic       tx_pin_o;
  logic       tx_pin_oe;
  logic       rx_pin_o;
  logic       rx_pin_oe;
  logic       rx_pullup;
  logic       remote_line;
  int         err_total       = 0;
  int         tests_run       = 0;
  // Undriven transmit wire floats high through its pull-up
  wire        tx_pin          = tx_pin_oe ? tx_pin_o : 1'b1;
  wire        rx_pin          = rx_pin_oe ? rx_pin_o : remote_line;

  always #5 clk = ~clk;

  asp_top u_dut (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .ce              (1'b1),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .global_irq_en   (global_irq_en),
    .tx_done_vec_ack (tx_done_vec_ack),
    .irq_rx_done     (irq_rx_done),
    .irq_tx_done     (irq_tx_done),
    .irq_tx_empty    (irq_tx_empty),
    .tx_pin_i        (tx_pin),
    .tx_pin_o        (tx_pin_o),
    .tx_pin_oe       (tx_pin_oe),
    .rx_pin_i        (rx_pin),
    .rx_pin_o        (rx_pin_o),
    .rx_pin_oe       (rx_pin_oe),
    .rx_pullup       (rx_pullup)
  );

  asp_remote #(.BIT_CLKS(BIT)) u_remote (
    .clk     (clk),
    .rx_line (remote_line),
    .tx_line (tx_pin)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk({2'b00, reg_rdata}, {2'b00, exp});
  endtask : rdc

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wait_frames(input int n);
    for (int i = 0; i < 4000 && u_remote.got_q.size() < n; i++)
      @(posedge clk);
  endtask : wait_frames

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(A_CTL, 8'h00);
    rdc(A_STA, 8'h20);
    rdc(3'h7, 8'h00);
  endtask : t_reset

  task automatic t_pins;
    wr(`ASP_OFS_PORT_DIR, 8'h01);
    // Both pin levels high, so handing the transmit pin over never dips it
    wr(`ASP_OFS_PORT_OUT, 8'h03);
    tick(2);
    chk({7'h00, tx_pin_oe, rx_pin_oe, rx_pin_o}, 10'h003);
    wr(`ASP_OFS_BAUD, BAUD);
    wr(A_CTL, 8'hd8);
    tick(2);
    chk({7'h00, tx_pin_oe, rx_pin_oe, rx_pullup}, 10'h005);
  endtask : t_pins

  task automatic t_tx;
    wr(A_DAT, 8'ha5);
    wr(A_DAT, 8'h3c);
    rdc(A_STA, 8'h00);
    wait_frames(2);
    chk(u_remote.got_q.pop_front(), 10'h1a5);
    chk(u_remote.got_q.pop_front(), 10'h13c);
    rdc(A_STA, 8'h20);
    for (int i = 0; i < 70 && irq_tx_done !== 1'b1; i++)
      @(posedge clk);
    rdc(A_STA, 8'h60);
    chk({9'h000, irq_tx_done}, 10'h001);
    @(posedge clk);
    tx_done_vec_ack <= 1'b1;
    @(posedge clk);
    tx_done_vec_ack <= 1'b0;
    rdc(A_STA, 8'h20);
    wr(A_CTL, 8'hf8);
    tick(2);
    chk({9'h000, irq_tx_empty}, 10'h001);
    @(posedge clk);
    global_irq_en <= 1'b0;
    tick(2);
    chk({9'h000, irq_tx_empty}, 10'h000);
    @(posedge clk);
    global_irq_en <= 1'b1;
    wr(A_CTL, 8'hd8);
  endtask : t_tx

  task automatic t_nine;
    u_remote.nbits = 9;
    wr(A_CTL, 8'hdd);
    wr(A_DAT, 8'h55);
    wait_frames(1);
    chk(u_remote.got_q.pop_front(), 10'h355);
    for (int i = 0; i < 100 && irq_tx_done !== 1'b1; i++)
      @(posedge clk);
    wr(A_STA, 8'h40);
    rdc(A_STA, 8'h20);
    u_remote.send(9'h1c3, 1'b1);
    rdc(A_CTL, 8'hdf);
    rdc(A_DAT, 8'hc3);
    wr(A_CTL, 8'hd8);
    u_remote.nbits = 8;
  endtask : t_nine

  task automatic t_rx;
    u_remote.send(9'h096, 1'b1);
    chk({9'h000, irq_rx_done}, 10'h001);
    rdc(A_STA, 8'ha0);
    rdc(A_DAT, 8'h96);
    rdc(A_STA, 8'h20);
  endtask : t_rx

  task automatic t_err;
    u_remote.send(9'h03a, 1'b0);
    rdc(A_STA, 8'hb0);
    rdc(A_DAT, 8'h3a);
    rdc(A_STA, 8'h20);
    // Let the low stop bit's false start die out first
    tick(BIT);
    u_remote.send(9'h011, 1'b1);
    u_remote.send(9'h022, 1'b1);
    rdc(A_STA, 8'ha8);
    rdc(A_DAT, 8'h11);
    rdc(A_STA, 8'h20);
  endtask : t_err

  task automatic t_noise;
    u_remote.spike(3 * (int'(BAUD) + 1));
    tick(2 * BIT);
    rdc(A_STA, 8'h20);
    u_remote.send(9'h0e1, 1'b1);
    rdc(A_DAT, 8'he1);
  endtask : t_noise

  task automatic t_off;
    // Receive pin back to input, so the remote line really reaches the port
    wr(`ASP_OFS_PORT_DIR, 8'h00);
    u_remote.send(9'h05a, 1'b1);
    wr(A_CTL, 8'hc8);
    u_remote.send(9'h077, 1'b1);
    rdc(A_STA, 8'ha0);
    rdc(A_DAT, 8'h5a);
    rdc(A_STA, 8'h20);
  endtask : t_off

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_pins();
    t_tx();
    t_nine();
    t_rx();
    t_err();
    t_noise();
    t_off();
    stop_test();
  end

  // Whole run needs about four thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule : asp_top_bench
